// ==== rtl/prs_defines.svh ====
`ifndef PRS_DEFINES_SVH
`define PRS_DEFINES_SVH

// timing figures, in their own units
`define PRS_CLK_PERIOD_NS 20
`define PRS_SCLK_PERIOD_NS 160
`define PRS_SHIFT_TIME_NS 60
// pclk cycles a config word stands before the next may follow
`define PRS_CFG_HOLD 3'h4
// reconfig clock rises the step request is held
`define PRS_HOLD_RISES 2'h2

// output counters on the larger variant
`define PRS_NUM_OUT 10

// counter select codes
`define PRS_SEL_ALL 4'h0
`define PRS_SEL_FB 4'h1
`define PRS_SEL_C0 4'h2

// counter word: low group [8:0], high group [17:9]
`define PRS_CW_W 18
`define PRS_CW_LOW_LSB 0
`define PRS_CW_ODD 8
`define PRS_CW_HIGH_LSB 9
`define PRS_CW_BYPASS 17

// counter word index on the link
`define PRS_IDX_PRE 4'h0
`define PRS_IDX_FB 4'h1
`define PRS_IDX_C0 4'h2

// controller register offsets
`define PRS_REG_CTRL 8'h00
`define PRS_REG_STATUS 8'h04
`define PRS_REG_LOOP 8'h08
`define PRS_REG_CNT 8'h0c

// ctrl fields
`define PRS_CTRL_GO 0
`define PRS_CTRL_DIR 1
`define PRS_CTRL_SEL_LSB 2
// status fields
`define PRS_ST_BUSY 0
`define PRS_ST_DONE 1
`define PRS_ST_REJECT 2
// loop fields
`define PRS_LOOP_PUMP_LSB 0
`define PRS_LOOP_RES_LSB 3
`define PRS_LOOP_CAP_LSB 8
`define PRS_LOOP_KBIT 10
// counter load fields
`define PRS_CNT_WORD_LSB 0
`define PRS_CNT_IDX_LSB 18

// reset values
`define PRS_TAP_RST 3'h0
`define PRS_PUMP_RST 3'h0
`define PRS_RES_RST 5'h00
`define PRS_CAP_RST 2'h0
`define PRS_KBIT_RST 1'b1
`define PRS_FACTOR_RST 9'h001

`endif

// ==== rtl/prs_pkg.sv ====
`include "prs_defines.svh"
package prs_pkg;
  // phase tap, eighths of a vco period
  typedef logic [2:0] prs_tap_t;
  // effective divide or multiply factor
  typedef logic [8:0] prs_factor_t;
  // one counter's configuration word
  typedef logic [`PRS_CW_W-1:0] prs_cword_t;
  // device step handshake states
  typedef enum logic [1:0] {
    PRS_D_IDLE = 2'b00,
    PRS_D_RISE1 = 2'b01,
    PRS_D_RISE2 = 2'b11,
    PRS_D_SHIFT = 2'b10
  } prs_dstate_t;
  // controller step sequence states
  typedef enum logic [2:0] {
    PRS_H_IDLE = 3'b000,
    PRS_H_SETUP = 3'b001,
    PRS_H_REQ = 3'b011,
    PRS_H_WAITHI = 3'b010,
    PRS_H_GAP = 3'b110
  } prs_hstate_t;
endpackage

// ==== rtl/prs_link_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface prs_link_if;
  logic scanclk;           // free-running reconfig clock
  logic shift_request;     // step request
  logic shift_direction;   // 1 later, 0 earlier
  logic [3:0] counter_select;
  logic shift_complete;    // high when ready
  logic cfg_toggle;        // flips once per config word
  logic [2:0] pump_current_code;
  logic [4:0] filter_res_code;
  logic [1:0] filter_cap_code;
  logic post_div_bit;      // 0 bypasses the post-scale divider
  logic [3:0] cnt_index;
  logic [17:0] cnt_word;
  // documented device end
  modport dev (
    input scanclk, shift_request, shift_direction, counter_select,
    input cfg_toggle, pump_current_code, filter_res_code, filter_cap_code,
    input post_div_bit, cnt_index, cnt_word,
    output shift_complete
  );
  // controlling end
  modport host (
    output scanclk, shift_request, shift_direction, counter_select,
    output cfg_toggle, pump_current_code, filter_res_code, filter_cap_code,
    output post_div_bit, cnt_index, cnt_word,
    input shift_complete
  );
endinterface
`default_nettype wire

// ==== rtl/prs_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module prs_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // foreign-domain bits in, safe bits out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r; // first stage, read only by q

  // two flops before any logic looks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule // prs_sync
`default_nettype wire

// ==== rtl/prs_device.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "prs_defines.svh"
module prs_device #(
  parameter int NUM_OUT = `PRS_NUM_OUT
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // link to the controlling party
  prs_link_if.dev link,
  // loop settings in force
  output logic [2:0] pump_code,
  output logic [4:0] res_code,
  output logic [1:0] cap_code,
  output prs_pkg::prs_factor_t post_div,
  // counter factors in force
  output prs_pkg::prs_factor_t pre_div,
  output prs_pkg::prs_factor_t fb_mul,
  output prs_pkg::prs_factor_t out_div [NUM_OUT],
  output logic [NUM_OUT-1:0] out_odd,
  // phase taps, index 0 feedback, 1.. outputs
  output prs_pkg::prs_tap_t tap_pos [NUM_OUT+1],
  // step status
  output logic shift_busy,
  output logic sel_bad
);
  import prs_pkg::*;

  localparam int SW = 41; // synchronised link bits
  localparam logic [3:0] SHIFT_CYC = 4'(
    (`PRS_SHIFT_TIME_NS + `PRS_CLK_PERIOD_NS - 1) / `PRS_CLK_PERIOD_NS);

  logic [SW-1:0] sync_q; // link after two flops
  logic sclk_s; // reconfig clock level
  logic req_s; // step request level
  logic dir_s; // direction level
  logic [3:0] sel_s; // counter select level
  logic tog_s; // config toggle level
  logic [2:0] pump_s;
  logic [4:0] res_s;
  logic [1:0] cap_s;
  logic kbit_s;
  logic [3:0] idx_s;
  prs_cword_t word_s;
  logic sclk_d_r; // previous reconfig clock level
  logic tog_d_r; // previous toggle level
  logic sclk_rise; // reconfig clock rose
  logic sclk_fall; // reconfig clock fell
  logic tog_chg; // new config word present
  prs_dstate_t state_r; // step handshake state
  logic armed_r; // request seen low since last step
  logic complete_r; // shift complete drive
  logic dir_r; // captured direction
  logic [NUM_OUT:0] mask_r; // captured target set
  logic [3:0] wait_r; // shift time left
  logic shift_fire; // taps move this cycle
  prs_tap_t tap_r [NUM_OUT+1];
  logic [2:0] pump_r;
  logic [4:0] res_r;
  logic [1:0] cap_r;
  logic kbit_r;
  prs_factor_t pre_r;
  prs_factor_t fb_r;
  prs_factor_t odiv_r [NUM_OUT];
  logic [NUM_OUT-1:0] odd_r;
  logic sel_bad_r;

  // select code to target set; out of range gives none
  function automatic logic [NUM_OUT:0] sel_mask(input logic [3:0] code);
    logic [NUM_OUT:0] m;
    m = '0;
    if (code == `PRS_SEL_ALL) begin
      m[NUM_OUT:1] = '1; // all output counters
    end else if (code == `PRS_SEL_FB) begin
      m[0] = 1'b1; // feedback counter
    end else if (int'(code) - int'(`PRS_SEL_C0) < NUM_OUT) begin
      m[int'(code) - int'(`PRS_SEL_C0) + 1] = 1'b1;
    end
    return m;
  endfunction

  // counter word to its effective factor
  function automatic prs_factor_t eff_factor(input prs_cword_t w);
    prs_factor_t f;
    f = 9'({1'b0, w[`PRS_CW_HIGH_LSB +: 8]}) + 9'({1'b0, w[`PRS_CW_LOW_LSB +: 8]});
    if (w[`PRS_CW_BYPASS]) begin
      f = `PRS_FACTOR_RST;
    end
    return f;
  endfunction

  // every link input passes two flops
  prs_sync #(.W(SW)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({link.scanclk, link.shift_request, link.shift_direction,
        link.counter_select, link.cfg_toggle, link.pump_current_code,
        link.filter_res_code, link.filter_cap_code, link.post_div_bit,
        link.cnt_index, link.cnt_word}),
    .q(sync_q)
  );
  assign {sclk_s, req_s, dir_s, sel_s, tog_s, pump_s, res_s, cap_s,
          kbit_s, idx_s, word_s} = sync_q;

  // edge finders on synchronised levels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_d_r <= 1'b0;
      tog_d_r <= 1'b0;
    end else begin
      sclk_d_r <= sclk_s;
      tog_d_r <= tog_s;
    end
  end
  assign sclk_rise = sclk_s & ~sclk_d_r;
  assign sclk_fall = ~sclk_s & sclk_d_r;
  assign tog_chg = tog_s ^ tog_d_r;

  // step handshake sequence
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= PRS_D_IDLE;
      complete_r <= 1'b1;
      dir_r <= 1'b0;
      mask_r <= '0;
      wait_r <= 4'h0;
      sel_bad_r <= 1'b0;
    end else begin
      unique case (state_r)
        PRS_D_IDLE: begin
          // request latched on the falling edge
          if (sclk_fall && req_s && armed_r) begin
            state_r <= PRS_D_RISE1;
          end
        end
        PRS_D_RISE1: begin
          // first rise after the latch
          if (sclk_rise) begin
            state_r <= PRS_D_RISE2;
          end
        end
        PRS_D_RISE2: begin
          // second rise: capture controls, drop complete
          if (sclk_rise) begin
            dir_r <= dir_s;
            mask_r <= sel_mask(sel_s);
            sel_bad_r <= (sel_mask(sel_s) == '0);
            complete_r <= 1'b0;
            wait_r <= SHIFT_CYC - 4'h1;
            state_r <= PRS_D_SHIFT;
          end
        end
        PRS_D_SHIFT: begin
          // complete stays low until the taps have moved
          if (wait_r == 4'h0) begin
            complete_r <= 1'b1;
            state_r <= PRS_D_IDLE;
          end else begin
            wait_r <= wait_r - 4'h1;
          end
        end
      endcase
    end
  end

  // one step per pulse: rearm only after request low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_r <= 1'b1;
    end else if (state_r == PRS_D_IDLE && sclk_fall && req_s && armed_r) begin
      armed_r <= 1'b0;
    end else if (sclk_fall && !req_s) begin
      armed_r <= 1'b1;
    end
  end

  assign shift_fire = (state_r == PRS_D_SHIFT) && (wait_r == 4'h0);

  // tap selection only; no counter is held or reset
  for (genvar g = 0; g <= NUM_OUT; g++) begin : g_tap
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        tap_r[g] <= `PRS_TAP_RST;
      end else if (shift_fire && mask_r[g]) begin
        tap_r[g] <= dir_r ? tap_r[g] + 3'h1 : tap_r[g] - 3'h1;
      end
    end
    assign tap_pos[g] = tap_r[g];
  end

  // loop settings reload on every config word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pump_r <= `PRS_PUMP_RST;
      res_r <= `PRS_RES_RST;
      cap_r <= `PRS_CAP_RST;
      kbit_r <= `PRS_KBIT_RST;
    end else if (tog_chg) begin
      pump_r <= pump_s;
      res_r <= res_s;
      cap_r <= cap_s;
      kbit_r <= kbit_s;
    end
  end

  // counter factors reload by index
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_r <= `PRS_FACTOR_RST;
      fb_r <= `PRS_FACTOR_RST;
      odiv_r <= '{default: `PRS_FACTOR_RST};
      odd_r <= '0;
    end else if (tog_chg) begin
      if (idx_s == `PRS_IDX_PRE) begin
        pre_r <= eff_factor(word_s);
      end else if (idx_s == `PRS_IDX_FB) begin
        fb_r <= eff_factor(word_s);
      end else if (int'(idx_s) - int'(`PRS_IDX_C0) < NUM_OUT) begin
        odiv_r[int'(idx_s) - int'(`PRS_IDX_C0)] <= eff_factor(word_s);
        odd_r[int'(idx_s) - int'(`PRS_IDX_C0)] <= word_s[`PRS_CW_ODD];
      end
    end
  end

  // outputs
  assign pump_code = pump_r;
  assign res_code = res_r;
  assign cap_code = cap_r;
  assign post_div = kbit_r ? 9'h002 : `PRS_FACTOR_RST;
  assign pre_div = pre_r;
  assign fb_mul = fb_r;
  assign out_div = odiv_r;
  assign out_odd = odd_r;
  assign shift_busy = (state_r != PRS_D_IDLE);
  assign sel_bad = sel_bad_r;
  assign link.shift_complete = complete_r;

endmodule // prs_device
`default_nettype wire

// ==== rtl/prs_host.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "prs_defines.svh"
module prs_host (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // link to the device
  prs_link_if.host link
);
  import prs_pkg::*;

  localparam logic [1:0] SCLK_HALF = 2'(
    `PRS_SCLK_PERIOD_NS / (2 * `PRS_CLK_PERIOD_NS) - 1);

  logic [1:0] div_r; // divider count
  logic sclk_r; // reconfig clock drive
  logic rise_ev; // reconfig clock rises next edge
  logic cmp_s; // complete after two flops
  prs_hstate_t state_r;
  logic req_r;
  logic dir_r;
  logic [3:0] sel_r;
  logic [1:0] hold_r; // rises seen while request high
  logic seen_low_r; // complete seen low
  logic done_r; // last step finished
  logic [2:0] cfg_hold_r; // config word settle
  logic tog_r;
  logic [2:0] pump_r;
  logic [4:0] res_r;
  logic [1:0] cap_r;
  logic kbit_r;
  logic [3:0] idx_r;
  prs_cword_t word_r;
  logic reject_r;
  logic wr_ev; // write takes effect
  logic loop_ok;

  // legal pump, resistor and capacitor codes
  function automatic logic code_ok(input logic [31:0] w);
    logic [2:0] p;
    logic [4:0] r;
    logic [1:0] c;
    p = w[`PRS_LOOP_PUMP_LSB +: 3];
    r = w[`PRS_LOOP_RES_LSB +: 5];
    c = w[`PRS_LOOP_CAP_LSB +: 2];
    return (p == 3'h0 || p == 3'h1 || p == 3'h3 || p == 3'h7) &&
           (r == 5'h00 || r == 5'h03 || r == 5'h04 || r == 5'h08 ||
            r == 5'h10 || r == 5'h13 || r == 5'h14 || r == 5'h18 ||
            r == 5'h1b || r == 5'h1c || r == 5'h1e) &&
           (c == 2'h0 || c == 2'h1 || c == 2'h3);
  endfunction

  // free-running reconfig clock from a divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= 2'h0;
      sclk_r <= 1'b0;
    end else if (div_r == SCLK_HALF) begin
      div_r <= 2'h0;
      sclk_r <= ~sclk_r;
    end else begin
      div_r <= div_r + 2'h1;
    end
  end
  assign rise_ev = (div_r == SCLK_HALF) && !sclk_r;

  // complete arrives from the device domain
  prs_sync #(.W(1)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(link.shift_complete),
    .q(cmp_s)
  );

  assign wr_ev = psel && penable && pready && pwrite;
  assign loop_ok = code_ok(pwdata);

  // step sequence
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= PRS_H_IDLE;
      req_r <= 1'b0;
      dir_r <= 1'b0;
      sel_r <= 4'h0;
      hold_r <= 2'h0;
      seen_low_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      unique case (state_r)
        PRS_H_IDLE: begin
          // go while idle; go while busy is ignored
          if (wr_ev && paddr == `PRS_REG_CTRL && pwdata[`PRS_CTRL_GO]) begin
            dir_r <= pwdata[`PRS_CTRL_DIR];
            sel_r <= pwdata[`PRS_CTRL_SEL_LSB +: 4];
            done_r <= 1'b0;
            state_r <= PRS_H_SETUP;
          end
        end
        PRS_H_SETUP: begin
          // controls stand a full cycle before the request
          if (rise_ev) begin
            req_r <= 1'b1;
            hold_r <= 2'h0;
            seen_low_r <= 1'b0;
            state_r <= PRS_H_REQ;
          end
        end
        PRS_H_REQ: begin
          if (rise_ev && hold_r != `PRS_HOLD_RISES) begin
            hold_r <= hold_r + 2'h1;
          end
          if (!cmp_s) begin
            seen_low_r <= 1'b1;
          end
          if (hold_r == `PRS_HOLD_RISES && seen_low_r) begin
            req_r <= 1'b0;
            state_r <= PRS_H_WAITHI;
          end
        end
        PRS_H_WAITHI: begin
          // next step only after complete returns
          if (cmp_s) begin
            state_r <= PRS_H_GAP;
          end
        end
        PRS_H_GAP: begin
          // request stays low at least one more cycle
          if (rise_ev) begin
            done_r <= 1'b1;
            state_r <= PRS_H_IDLE;
          end
        end
        default: begin
          state_r <= PRS_H_IDLE;
        end
      endcase
    end
  end

  // config words; illegal loop codes refused
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_hold_r <= 3'h0;
      tog_r <= 1'b0;
      pump_r <= `PRS_PUMP_RST;
      res_r <= `PRS_RES_RST;
      cap_r <= `PRS_CAP_RST;
      kbit_r <= `PRS_KBIT_RST;
      idx_r <= 4'hf;
      word_r <= '0;
      reject_r <= 1'b0;
    end else if (wr_ev && paddr == `PRS_REG_LOOP) begin
      reject_r <= !loop_ok;
      if (loop_ok) begin
        pump_r <= pwdata[`PRS_LOOP_PUMP_LSB +: 3];
        res_r <= pwdata[`PRS_LOOP_RES_LSB +: 5];
        cap_r <= pwdata[`PRS_LOOP_CAP_LSB +: 2];
        kbit_r <= pwdata[`PRS_LOOP_KBIT];
        idx_r <= 4'hf; // no counter touched
        tog_r <= ~tog_r;
        cfg_hold_r <= `PRS_CFG_HOLD;
      end
    end else if (wr_ev && paddr == `PRS_REG_CNT) begin
      word_r <= pwdata[`PRS_CNT_WORD_LSB +: 18];
      idx_r <= pwdata[`PRS_CNT_IDX_LSB +: 4];
      tog_r <= ~tog_r;
      cfg_hold_r <= `PRS_CFG_HOLD;
    end else if (cfg_hold_r != 3'h0) begin
      cfg_hold_r <= cfg_hold_r - 3'h1;
    end
  end

  // read data and error set up in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      unique case (paddr)
        `PRS_REG_CTRL: prdata <= {26'h0, sel_r, dir_r, 1'b0};
        `PRS_REG_STATUS: prdata <= {29'h0, reject_r, done_r, state_r != PRS_H_IDLE};
        `PRS_REG_LOOP: prdata <= {21'h0, kbit_r, cap_r, res_r, pump_r};
        `PRS_REG_CNT: prdata <= {10'h0, idx_r, word_r};
        default: pslverr <= 1'b1; // unmapped
      endcase
    end
  end

  // stall any access while a config word settles
  assign pready = (cfg_hold_r == 3'h0);

  // link drive
  assign link.scanclk = sclk_r;
  assign link.shift_request = req_r;
  assign link.shift_direction = dir_r;
  assign link.counter_select = sel_r;
  assign link.cfg_toggle = tog_r;
  assign link.pump_current_code = pump_r;
  assign link.filter_res_code = res_r;
  assign link.filter_cap_code = cap_r;
  assign link.post_div_bit = kbit_r;
  assign link.cnt_index = idx_r;
  assign link.cnt_word = word_r;

endmodule // prs_host
`default_nettype wire

// ==== test/prs_link_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module prs_link_properties (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // step handshake
  input wire logic scanclk,
  input wire logic shift_request,
  input wire logic shift_direction,
  input wire logic [3:0] counter_select,
  input wire logic shift_complete,
  // loop codes
  input wire logic [2:0] pump_current_code,
  input wire logic [4:0] filter_res_code,
  input wire logic [1:0] filter_cap_code
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [4:0] held_r; // pclk cycles request high, saturating
  logic seen_low_r; // complete seen low during this request
  // length of the current request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) held_r <= 5'h00;
    else if (!shift_request) held_r <= 5'h00;
    else if (held_r != 5'h1f) held_r <= held_r + 5'h01;
  end
  // complete low seen while request up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) seen_low_r <= 1'b0;
    else if (!shift_request) seen_low_r <= 1'b0;
    else if (!shift_complete) seen_low_r <= 1'b1;
  end
  // complete returns within a bound
  sequence done_back_s;
    ##[1:16] $rose(shift_complete);
  endsequence
  pump_legal_a: assert property (
    pump_current_code inside {3'h0, 3'h1, 3'h3, 3'h7}) else $error("pump code illegal");
  filter_legal_a: assert property (
    filter_res_code inside {5'h00, 5'h03, 5'h04, 5'h08, 5'h10, 5'h13, 5'h14, 5'h18, 5'h1b,
    5'h1c, 5'h1e} && filter_cap_code != 2'h2) else $error("filter code illegal");
  clk_high_a: assert property (
    $rose(scanclk) |-> ##[1:7] $fell(scanclk)) else $error("reconfig clock stuck high");
  clk_low_a: assert property (
    $fell(scanclk) |-> ##[1:7] $rose(scanclk)) else $error("reconfig clock stuck low");
  req_hold_a: assert property (
    $fell(shift_request) |-> held_r >= 5'h10) else $error("request held too short");
  req_drop_a: assert property (
    $fell(shift_request) |-> seen_low_r) else $error("request dropped before complete low");
  req_gap_a: assert property (
    $fell(shift_request) |-> !shift_request [*8]) else $error("request gap too short");
  req_start_a: assert property (
    $rose(shift_request) |-> shift_complete) else $error("request while shift running");
  ctl_stable_a: assert property (
    shift_request && $past(shift_request) |-> $stable(counter_select) && $stable(shift_direction))
    else $error("controls moved during request");
  done_low_a: assert property (
    $fell(shift_complete) |-> shift_request ##0 done_back_s) else $error("complete low wrong");
endmodule // prs_link_properties
`default_nettype wire

// ==== test/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import prs_pkg::*;
  // clock, reset, apb
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic err;
  // device outputs
  logic [2:0] pump_code;
  logic [4:0] res_code;
  logic [1:0] cap_code;
  prs_factor_t post_div, pre_div, fb_mul;
  prs_factor_t out_div [10];
  logic [9:0] out_odd;
  prs_tap_t tap_pos [11];
  prs_tap_t exp_tap [11];
  logic shift_busy, sel_bad;
  logic [10:0] cur; // loop word in force
  logic [3:0] idx;
  prs_factor_t f;
  int miscompares, cmp_count, cycles;
  // loop words: {legal, post, cap, res, pump}
  localparam logic [11:0] LT [6] = '{12'hbf7, 12'h51a, 12'h429, 12'h29b, 12'hdd9, 12'h0f8};
  // counter loads {index, word} and factors
  localparam logic [21:0] CT [6] = '{22'h000602, 22'h020602, 22'h040806, 22'h060806,
    22'h080501, 22'h2dfeff};
  localparam logic [8:0] CF [6] = '{9'h005, 9'h001, 9'h00a, 9'h001, 9'h003, 9'h1fe};
  prs_link_if link ();
  prs_host u_prs_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link));
  prs_device #(.NUM_OUT(10)) u_prs_device (.pclk(pclk), .presetn(presetn), .link(link),
    .pump_code(pump_code), .res_code(res_code), .cap_code(cap_code), .post_div(post_div),
    .pre_div(pre_div), .fb_mul(fb_mul), .out_div(out_div), .out_odd(out_odd),
    .tap_pos(tap_pos), .shift_busy(shift_busy), .sel_bad(sel_bad));
  prs_link_properties props (.pclk(pclk), .presetn(presetn), .scanclk(link.scanclk),
    .shift_request(link.shift_request), .shift_direction(link.shift_direction),
    .counter_select(link.counter_select), .shift_complete(link.shift_complete),
    .pump_current_code(link.pump_current_code), .filter_res_code(link.filter_res_code),
    .filter_cap_code(link.filter_cap_code));
  // 50 MHz clock
  always #10 pclk = ~pclk;
  // hang guard
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      end_sim();
    end
  end
  // compare and count
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one apb transfer, waits on pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no local cap: only the hang guard ends a stalled access
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // one phase step, then every tap against the model
  task automatic step(input logic [3:0] sel, input logic dir);
    apb(1'b1, 8'h00, {26'h0, sel, dir, 1'b1});
    // a step that never answers is caught by the hang guard
    while (link.shift_complete !== 1'b0) begin
      @(posedge pclk);
    end
    chk("request", link.shift_request, 32'h1);
    chk("select", link.counter_select, sel);
    do begin
      apb(1'b0, 8'h04, 32'h0);
    end while (rd[1] !== 1'b1);
    chk("busy", rd[0], 32'h0);
    for (int i = 0; i < 11; i++)
      if ((sel == 4'h0 && i > 0) || (sel != 4'h0 && i == sel - 1)) exp_tap[i] += dir ? 3'h1 : 3'h7;
    for (int i = 0; i < 11; i++) chk("tap", tap_pos[i], exp_tap[i]);
    chk("sel_bad", sel_bad, sel > 4'hb);
    chk("shift_busy", shift_busy, 32'h0);
  endtask
  // verdict
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // main sequence
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    miscompares = 0;
    cmp_count = 0;
    cycles = 0;
    cur = 11'h400;
    foreach (exp_tap[i]) exp_tap[i] = 3'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    chk("post_div", post_div, 32'h2);
    chk("pre_div", pre_div, 32'h1);
    chk("complete", link.shift_complete, 32'h1);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped err", err, 32'h1);
    chk("unmapped data", rd, 32'h0);
    // feedback wraps downward first
    step(4'h1, 1'b0);
    for (int s = 0; s < 12; s++) step(4'(s), 1'b1);
    step(4'hf, 1'b1);
    step(4'h6, 1'b0);
    apb(1'b0, 8'h00, 32'h0);
    chk("ctrl", rd, 32'h18);
    // loop settings, legal and refused
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, 8'h08, {21'h0, LT[i][10:0]});
      if (LT[i][11]) cur = LT[i][10:0];
      repeat (8) @(posedge pclk);
      chk("pump", pump_code, cur[2:0]);
      chk("res", res_code, cur[7:3]);
      chk("cap", cap_code, cur[9:8]);
      chk("post", post_div, cur[10] ? 32'h2 : 32'h1);
      apb(1'b0, 8'h04, 32'h0);
      chk("reject", rd[2], !LT[i][11]);
    end
    // counter factors and bypass
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, 8'h0c, {10'h0, CT[i]});
      repeat (8) @(posedge pclk);
      idx = CT[i][21:18];
      f = (idx == 4'h0) ? pre_div : (idx == 4'h1) ? fb_mul : out_div[idx - 4'h2];
      chk("factor", f, CF[i]);
    end
    chk("odd", out_odd, 32'h1);
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
